// File: pot_pkg.sv
// Shared constants for the serial digital potentiometer link and its host controller.
`default_nettype none
package pot_pkg;
  // ==========================================================================
  // Register layout
  localparam int PRESET_WIDTH = 6;
  localparam int PRESET_COUNT = 4;
  localparam int TAP_COUNT = 64;
  localparam logic [5:0] WIPER_RESET = 6'h00;
  localparam logic [5:0] PRESET_RESET = 6'h00;
  localparam logic [5:0] TAP_MAX = 6'h3f;
  localparam logic [5:0] TAP_MIN = 6'h00;
  // ==========================================================================
  // Frame layout
  // Arbitrary type code: any value serves as long as both ends share it.
  localparam logic [3:0] DEVICE_TYPE_ID = 4'ha;
  localparam logic [2:0] ID_MIDDLE_BITS = 3'h6;
  localparam logic [3:0] OP_READ_WIPER = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
  localparam logic [3:0] OP_READ_PRESET = 4'hb;
  localparam logic [3:0] OP_WRITE_PRESET = 4'hc;
  localparam logic [3:0] OP_PRESET_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_PRESET = 4'he;
  localparam logic [3:0] OP_STEP_WIPER = 4'h2;
  localparam logic [3:0] OP_READ_STATUS = 4'h5;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;
  localparam int LINK_HALF_CYCLES = 4;
  // ==========================================================================
  // Host register map (APB byte offsets)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RDATA_OFFSET = 8'h08;
  localparam int CTRL_GO_BIT = 31;
  localparam int CTRL_OP_LSB = 16;
  localparam int CTRL_REG_LSB = 12;
  localparam int CTRL_ADDR_BIT = 8;
  localparam int STATUS_BUSY_BIT = 0;
endpackage
`default_nettype wire

// File: pot_link_if.sv
// Serial link between the potentiometer device and its host controller.
`default_nettype none
interface pot_link_if;
  logic sel_n;
  logic sck;
  logic si;
  logic so_out;
  logic so_oe;
  logic pause_n;
  logic wprot_n;
  // The data wire reads the device output while it drives, else a constant high.
  logic data_wire;
  assign data_wire = so_oe ? so_out : 1'b1;
  modport device (
    input sel_n,
    input sck,
    input si,
    input pause_n,
    input wprot_n,
    output so_out,
    output so_oe
  );
  modport host (
    output sel_n,
    output sck,
    output si,
    output pause_n,
    output wprot_n,
    input data_wire
  );
endinterface
`default_nettype wire

// File: pot_device.sv
// Serial slave, wiper counter and preset store of the digital potentiometer.
`default_nettype none
// Operation
// - Output bits change on falling link clock.
// - Input bits sampled on rising link clock.
// - Deselected: output released, standby unless writing.
// - Ignore activity until first select fall.
// - Pause low freezes sequence; changes at clock low.
// - Host holds pause high when unused.
// - Address bit must match address pin.
// - At most two devices per bus.
// - Write-protect low blocks preset writes only.
// - Host keeps select high, pause/protect high.
// - Output tri-stated unless driving read data.
// - Wiper counter decoded one-hot to 64 taps.
// - Wiper loads serially, from preset, or stepwise.
// - Power-up loads wiper from preset zero.
// - Wiper volatile; power-up value from preset zero.
// - Four 6-bit presets, readable, writable, transferable.
// - Preset change is a 10 ms write.
// - Preset reads as 8 bits, top two zero.
// - Wiper reads as 8 bits, top two zero.
// - Preset commits on select rise; busy flag.
// - Step up with input high, down with low.
module pot_device
  import pot_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Link
  pot_link_if.device link,
  // Pins and analog side
  input wire logic device_addr_bit,
  output logic [TAP_COUNT-1:0] tap_enable,
  output logic nv_write_busy_flag,
  output logic standby
);
  if (NV_CYCLES < 1) begin : g_bad_nv
    $error("NV_CYCLES must be at least one");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ID = 5'b00010,
    ST_INSTR = 5'b00100,
    ST_DATA = 5'b01000,
    ST_STEP = 5'b10000
  } dev_state_type;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] sck_sync_reg, sel_sync_reg, si_sync_reg, hold_sync_reg, wp_sync_reg, addr_sync_reg;
  logic sck_prev_reg, sel_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_sync_reg <= 2'b00;
      sel_sync_reg <= 2'b11;
      si_sync_reg <= 2'b00;
      hold_sync_reg <= 2'b11;
      wp_sync_reg <= 2'b11;
      addr_sync_reg <= 2'b00;
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
    end else if (clk_en) begin
      sck_sync_reg <= {sck_sync_reg[0], link.sck};
      sel_sync_reg <= {sel_sync_reg[0], link.sel_n};
      si_sync_reg <= {si_sync_reg[0], link.si};
      hold_sync_reg <= {hold_sync_reg[0], link.pause_n};
      wp_sync_reg <= {wp_sync_reg[0], link.wprot_n};
      addr_sync_reg <= {addr_sync_reg[0], device_addr_bit};
      sck_prev_reg <= sck_sync_reg[1];
      sel_prev_reg <= sel_sync_reg[1];
    end
  end
  logic sel_n, sck_s, paused;
  assign sel_n = sel_sync_reg[1];
  assign sck_s = sck_sync_reg[1];
  // Pause only takes effect while the link clock is low, so edges never slip.
  logic hold_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (clk_en && !sck_s) begin
      hold_reg <= !hold_sync_reg[1];
    end
  end
  assign paused = hold_reg;
  logic rise, fall, sel_fall, sel_rise;
  assign rise = clk_en && !sel_n && !paused && sck_s && !sck_prev_reg;
  assign fall = clk_en && !sel_n && !paused && !sck_s && sck_prev_reg;
  assign sel_fall = clk_en && !sel_n && sel_prev_reg;
  assign sel_rise = clk_en && sel_n && !sel_prev_reg;

  // ==========================================================================
  // Serial sequencer
  dev_state_type state_reg;
  logic armed_reg, out_en_reg, out_bit_reg, commit_pend_reg, load_done_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic [3:0] op_reg;
  logic [1:0] sel_reg_reg;
  logic [5:0] wiper_reg;
  logic [5:0] preset_reg [PRESET_COUNT];
  logic [5:0] pend_data_reg;
  logic [1:0] pend_idx_reg;
  logic [31:0] nv_cnt_reg;
  logic [7:0] rx_byte;
  logic nv_busy;
  assign rx_byte = {shift_reg[6:0], si_sync_reg[1]};
  assign nv_busy = nv_cnt_reg != 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (sel_fall) begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      op_reg <= 4'h0;
      sel_reg_reg <= 2'h0;
      tx_reg <= 8'h00;
      out_en_reg <= 1'b0;
      out_bit_reg <= 1'b0;
      commit_pend_reg <= 1'b0;
      pend_data_reg <= 6'h00;
      pend_idx_reg <= 2'h0;
      wiper_reg <= WIPER_RESET;
      load_done_reg <= 1'b0;
    end else if (clk_en) begin
      if (!load_done_reg) begin
        wiper_reg <= preset_reg[0];
        load_done_reg <= 1'b1;
      end
      if (sel_n) begin
        state_reg <= ST_IDLE;
        out_en_reg <= 1'b0;
        bit_cnt_reg <= 3'h0;
      end else if (sel_fall) begin
        state_reg <= ST_ID;
        bit_cnt_reg <= 3'h0;
        commit_pend_reg <= 1'b0;
      end else if (rise && armed_reg) begin
        shift_reg <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        case (state_reg)
          ST_ID: begin
            if (bit_cnt_reg == 3'h7) begin
              if (rx_byte[7:4] == DEVICE_TYPE_ID && rx_byte[3:1] == ID_MIDDLE_BITS
                  && rx_byte[0] == addr_sync_reg[1]) begin
                state_reg <= ST_INSTR;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_INSTR: begin
            if (bit_cnt_reg == 3'h7) begin
              op_reg <= rx_byte[7:4];
              sel_reg_reg <= rx_byte[3:2];
              state_reg <= ST_DATA;
              case (rx_byte[7:4])
                OP_READ_WIPER: tx_reg <= {2'b00, wiper_reg};
                OP_READ_PRESET: tx_reg <= {2'b00, preset_reg[rx_byte[3:2]]};
                OP_READ_STATUS: tx_reg <= {7'h00, nv_busy};
                OP_PRESET_TO_WIPER: begin
                  wiper_reg <= preset_reg[rx_byte[3:2]];
                  state_reg <= ST_IDLE;
                end
                OP_WIPER_TO_PRESET: begin
                  pend_data_reg <= wiper_reg;
                  pend_idx_reg <= rx_byte[3:2];
                  commit_pend_reg <= 1'b1;
                  state_reg <= ST_IDLE;
                end
                OP_STEP_WIPER: state_reg <= ST_STEP;
                OP_WRITE_WIPER, OP_WRITE_PRESET: tx_reg <= 8'h00;
                default: state_reg <= ST_IDLE;
              endcase
            end
          end
          ST_DATA: begin
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= ST_IDLE;
              if (op_reg == OP_WRITE_WIPER) begin
                wiper_reg <= rx_byte[5:0];
              end
              if (op_reg == OP_WRITE_PRESET) begin
                pend_data_reg <= rx_byte[5:0];
                pend_idx_reg <= sel_reg_reg;
                commit_pend_reg <= 1'b1;
              end
            end
          end
          ST_STEP: begin
            if (si_sync_reg[1] && wiper_reg != TAP_MAX) begin
              wiper_reg <= wiper_reg + 6'h01;
            end else if (!si_sync_reg[1] && wiper_reg != TAP_MIN) begin
              wiper_reg <= wiper_reg - 6'h01;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else if (fall) begin
        if (state_reg == ST_DATA && (op_reg == OP_READ_WIPER
            || op_reg == OP_READ_PRESET || op_reg == OP_READ_STATUS)) begin
          out_en_reg <= 1'b1;
          out_bit_reg <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end else begin
          out_en_reg <= 1'b0;
        end
      end
      if (sel_rise) begin
        commit_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Nonvolatile preset store
  // A commit is only launched on the select rise after a complete write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_cnt_reg <= 32'h0000_0000;
      for (int i = 0; i < PRESET_COUNT; i++) begin
        preset_reg[i] <= PRESET_RESET;
      end
    end else if (clk_en) begin
      if (sel_rise && commit_pend_reg && wp_sync_reg[1] && !nv_busy) begin
        preset_reg[pend_idx_reg] <= pend_data_reg;
        nv_cnt_reg <= 32'(NV_CYCLES);
      end else if (nv_busy) begin
        nv_cnt_reg <= nv_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Tap decode
  genvar g;
  generate
    for (g = 0; g < TAP_COUNT; g++) begin : g_tap
      assign tap_enable[g] = wiper_reg == 6'(g);
    end
  endgenerate

  assign link.so_out = out_bit_reg;
  assign link.so_oe = out_en_reg && !sel_n;
  assign nv_write_busy_flag = nv_busy;
  assign standby = sel_n && !nv_busy;
endmodule
`default_nettype wire

// File: pot_host.sv
// APB-controlled host end that runs frames on the potentiometer link.
`default_nettype none
module pot_host
  import pot_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  pot_link_if.host link,
  // Board pins
  input wire logic wprot_req_n
);
  // The read sample needs three cycles of high phase to cover both synchronisers.
  if (HALF_CYCLES < 3) begin : g_bad_half
    $error("HALF_CYCLES must be at least three");
  end

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_END = 3'b100
  } host_state_type;

  host_state_type state_reg;
  logic [23:0] tx_reg;
  logic [7:0] rx_reg;
  logic [4:0] bits_left_reg;
  logic [7:0] div_reg;
  logic sck_reg, sel_n_reg;
  logic [1:0] din_sync_reg;
  logic apb_wr, go;
  assign apb_wr = psel && penable && pwrite;
  assign go = apb_wr && paddr == CTRL_OFFSET && pwdata[CTRL_GO_BIT] && state_reg == HS_IDLE;

  // ==========================================================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == CTRL_OFFSET || paddr == STATUS_OFFSET
                   || paddr == RDATA_OFFSET);
  // Read data is latched in the setup cycle, so the access cycle needs no wait state;
  // the busy bit may therefore be one cycle old.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        STATUS_OFFSET: prdata <= {31'h0000_0000, state_reg != HS_IDLE};
        RDATA_OFFSET: prdata <= {24'h00_0000, rx_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_sync_reg <= 2'b11;
    end else if (clk_en) begin
      din_sync_reg <= {din_sync_reg[0], link.data_wire};
    end
  end

  // ==========================================================================
  // Frame engine: sends ID, instruction and a data byte, samples read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HS_IDLE;
      tx_reg <= 24'h00_0000;
      rx_reg <= 8'h00;
      bits_left_reg <= 5'h00;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      sel_n_reg <= 1'b1;
    end else if (clk_en) begin
      case (state_reg)
        HS_IDLE: begin
          if (go) begin
            tx_reg <= {DEVICE_TYPE_ID, ID_MIDDLE_BITS, pwdata[CTRL_ADDR_BIT],
                       pwdata[CTRL_OP_LSB+3:CTRL_OP_LSB], pwdata[CTRL_REG_LSB+1:CTRL_REG_LSB],
                       2'b00, 2'b00, pwdata[5:0]};
            bits_left_reg <= 5'd24;
            sel_n_reg <= 1'b0;
            div_reg <= 8'h00;
            state_reg <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (div_reg == 8'(HALF_CYCLES - 1)) begin
            div_reg <= 8'h00;
            if (!sck_reg) begin
              sck_reg <= 1'b1;
            end else begin
              sck_reg <= 1'b0;
              // Sample at the end of the high phase: the device answer lags its own
              // synchroniser and then ours, so the rising edge would still see the old bit.
              rx_reg <= {rx_reg[6:0], din_sync_reg[1]};
              tx_reg <= {tx_reg[22:0], 1'b0};
              bits_left_reg <= bits_left_reg - 5'h01;
              if (bits_left_reg == 5'h01) begin
                state_reg <= HS_END;
              end
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        HS_END: begin
          if (div_reg == 8'(HALF_CYCLES - 1)) begin
            sel_n_reg <= 1'b1;
            state_reg <= HS_IDLE;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.sck = sck_reg;
  assign link.sel_n = sel_n_reg;
  assign link.si = tx_reg[23];
  assign link.pause_n = 1'b1;
  assign link.wprot_n = wprot_req_n;
endmodule
`default_nettype wire

// File: pot_link_monitor.sv
// Concurrent checks on the potentiometer link and the device pins.
`default_nettype none
module pot_link_monitor
  import pot_pkg::*;
#(
  parameter int NV_CYCLES = 50
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic sel_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic pause_n,
  input wire logic wprot_n,
  input wire logic data_wire,
  // Device pins
  input wire logic [TAP_COUNT-1:0] tap_enable,
  input wire logic nv_write_busy_flag,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Helper counters
  // Rising link clocks inside the current frame.
  logic [5:0] rise_reg;
  // Consecutive cycles of the nonvolatile write, so its length can be bounded.
  logic [19:0] busy_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_reg <= 6'h00;
    end else if (sel_n) begin
      rise_reg <= 6'h00;
    end else if ($rose(sck)) begin
      rise_reg <= rise_reg + 6'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 20'h0_0000;
    end else if (nv_write_busy_flag) begin
      busy_reg <= busy_reg + 20'h0_0001;
    end else begin
      busy_reg <= 20'h0_0000;
    end
  end
  // ==========================================================================
  // Assertions
  a_idle_released: assert property (sel_n [*4] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_out_on_fall: assert property (so_oe && $changed(so_out) |-> !sck)
    else $error("serial output changed while link clock high");
  a_tap_one_hot: assert property ($onehot(tap_enable))
    else $error("tap switches not one-hot");
  a_commit_on_rise: assert property ($rose(nv_write_busy_flag) |-> sel_n && $past(sel_n))
    else $error("nonvolatile write started while selected");
  a_commit_bound: assert property (nv_write_busy_flag |-> busy_reg <= NV_CYCLES)
    else $error("nonvolatile write too long");
  a_standby_idle: assert property ((sel_n && !nv_write_busy_flag) [*4] |-> standby)
    else $error("standby missing while idle");
  a_active_awake: assert property (!sel_n [*4] |-> !standby)
    else $error("standby while selected");
  a_frame_bits: assert property ($rose(sel_n) |-> rise_reg == 6'h18)
    else $error("frame did not carry 24 clock rises");
  a_host_pins: assert property (!sel_n |-> pause_n && $stable(wprot_n))
    else $error("pause or protect moved inside a frame");
  a_wire_released: assert property (!so_oe |-> data_wire)
    else $error("shared data wire not released");
  c_commit: cover property ($rose(nv_write_busy_flag));
  c_read: cover property ($rose(so_oe));
  c_frame: cover property ($rose(sel_n));
endmodule
`default_nettype wire

// File: tb.sv
// Testbench joining the host and device ends over the link.
`default_nettype none
module tb
  import pot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV = 50;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] idx;
    logic [5:0] data;
    logic [1:0] kind;
    logic [7:0] exp;
  } row_type;
  // Kind 1 checks read data, kind 2 checks the enabled tap.
  localparam row_type rows [12] = '{
    '{OP_WRITE_WIPER, 2'h0, 6'h2a, 2'h2, 8'h2a},
    '{OP_READ_WIPER, 2'h0, 6'h00, 2'h1, 8'h2a},
    '{OP_WRITE_PRESET, 2'h1, 6'h15, 2'h0, 8'h00},
    '{OP_READ_PRESET, 2'h1, 6'h00, 2'h1, 8'h15},
    '{OP_PRESET_TO_WIPER, 2'h1, 6'h00, 2'h2, 8'h15},
    '{OP_WIPER_TO_PRESET, 2'h2, 6'h00, 2'h0, 8'h00},
    '{OP_READ_PRESET, 2'h2, 6'h00, 2'h1, 8'h15},
    '{OP_WRITE_PRESET, 2'h0, 6'h3f, 2'h0, 8'h00},
    '{OP_READ_PRESET, 2'h0, 6'h00, 2'h1, 8'h3f},
    '{OP_STEP_WIPER, 2'h0, 6'h3f, 2'h2, 8'h19},
    '{OP_READ_STATUS, 2'h0, 6'h00, 2'h1, 8'h00},
    '{OP_READ_WIPER, 2'h0, 6'h00, 2'h1, 8'h19}};
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wprot_req_n = 1'b1;
  logic device_addr_bit = 1'b1;
  logic [TAP_COUNT-1:0] tap_enable;
  logic busy;
  logic standby;
  logic [31:0] r;
  logic e;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  pot_link_if link ();
  pot_device #(.NV_CYCLES(NV)) pot_device_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .link(link), .device_addr_bit(device_addr_bit), .tap_enable(tap_enable),
    .nv_write_busy_flag(busy), .standby(standby));
  pot_host #(.HALF_CYCLES(4)) pot_host_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
    .wprot_req_n(wprot_req_n));
  pot_link_monitor #(.NV_CYCLES(NV)) pot_link_monitor_i (.pclk(pclk), .presetn(presetn),
    .sel_n(link.sel_n), .sck(link.sck), .si(link.si), .so_out(link.so_out),
    .so_oe(link.so_oe), .pause_n(link.pause_n), .wprot_n(link.wprot_n),
    .data_wire(link.data_wire), .tap_enable(tap_enable), .nv_write_busy_flag(busy),
    .standby(standby));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; returns one edge after the access phase.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic frame(input logic [3:0] op, input logic [1:0] idx, input logic [5:0] d,
                       input logic a);
    int n;
    apb(1'b1, CTRL_OFFSET, {1'b1, 11'h000, op, 2'h0, idx, 3'h0, a, 2'h0, d}, r, e);
    n = 0;
    do begin
      apb(1'b0, STATUS_OFFSET, 32'h0000_0000, r, e);
      n++;
    end while (r[STATUS_BUSY_BIT] !== 1'b0 && n < 500);
    // The device sees select through a synchroniser, so let it settle first.
    repeat (8) @(posedge pclk);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(64'(tap_enable), 64'(1));
    for (int i = 0; i < 12; i++) begin
      frame(rows[i].op, rows[i].idx, rows[i].data, 1'b1);
      if (rows[i].kind == 2'h1) begin
        apb(1'b0, RDATA_OFFSET, 32'h0000_0000, r, e);
        chk(64'(r[7:0]), 64'(rows[i].exp));
      end
      if (rows[i].kind == 2'h2) begin
        chk(tap_enable, 64'(1) << rows[i].exp);
      end
    end
    chk(64'(standby), 64'(1));
    chk(64'(link.data_wire), 64'(1));
    // An unmapped host register is refused.
    apb(1'b0, 8'h0c, 32'h0000_0000, r, e);
    chk(64'(e), 64'(1));
    // A frame for the other address leaves the wiper alone.
    frame(OP_WRITE_WIPER, 2'h0, 6'h01, 1'b0);
    chk(tap_enable, 64'(1) << 8'h19);
    wprot_req_n <= 1'b0;
    frame(OP_WRITE_PRESET, 2'h3, 6'h11, 1'b1);
    frame(OP_READ_PRESET, 2'h3, 6'h00, 1'b1);
    apb(1'b0, RDATA_OFFSET, 32'h0000_0000, r, e);
    chk(64'(r[7:0]), 64'(PRESET_RESET));
    frame(OP_WRITE_WIPER, 2'h0, 6'h07, 1'b1);
    chk(tap_enable, 64'(1) << 8'h07);
    wprot_req_n <= 1'b1;
    // A reset in mid-run brings the wiper back from preset zero.
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(tap_enable, 64'(1) << PRESET_RESET);
    // Eight steps down from the bottom tap must not wrap.
    frame(OP_STEP_WIPER, 2'h0, 6'h00, 1'b1);
    chk(tap_enable, 64'(1) << TAP_MIN);
    frame(OP_WRITE_WIPER, 2'h0, TAP_MAX, 1'b1);
    chk(tap_enable, 64'(1) << TAP_MAX);
    // Two steps down and six up from the top tap end at the top again.
    frame(OP_STEP_WIPER, 2'h0, 6'h3f, 1'b1);
    chk(tap_enable, 64'(1) << TAP_MAX);
    report_and_stop();
  end
endmodule
`default_nettype wire
